// ===== logic/dtc_top.sv
// Debug trigger control: control register, comparators, capture run and break requests
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [31:0]       i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic      [1:0]        o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [31:0]       i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic      [31:0]       o_rdata,
  output logic      [1:0]        o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire dtc_pkg::dtc_bus_t i_core_bus,
  input  wire logic              i_secure,
  output logic                   o_brk_req,
  output logic                   o_brk_tag,
  output logic                   o_irq
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]               ctrl;
    logic                     run_active_flag;
    logic                     trig_seen;
    logic                     begin_mode;
    logic                     src_or;
    logic [15:0]              cmpa;
    logic [15:0]              cmpb;
    logic [dtc_pkg::IRQ_W-1:0] irq_st;
    logic [dtc_pkg::IRQ_W-1:0] irq_en;
    logic                     irq;
    logic                     brk;
    logic                     brk_tag;
    logic                     sec1;
    logic                     sec2;
  } dtc_top_st_t;

  dtc_top_st_t       st_ff;
  dtc_top_st_t       nxt_st;
  dtc_pkg::dtc_req_t req;
  logic [31:0]       rd_data;
  logic              run;
  logic              hit_a;
  logic              hit_b;
  logic              trig;
  logic              push;
  logic              done;
  logic              f_clear;
  logic              f_pop;
  logic              f_full;
  logic              f_empty;
  logic [15:0]       f_data;
  logic [3:0]        f_count;
  logic              wr_ctrl;
  logic [7:0]        wctrl;
  logic [dtc_pkg::IRQ_W-1:0] irq_set;

  function automatic logic cmp_hit(input dtc_pkg::dtc_bus_t b, input logic [15:0] a,
                                   input logic qen, input logic dir);
    return b.valid && (b.addr == a) && (!qen || (b.rd == dir));
  endfunction

  // ==========================================================================
  // Bus slave and capture buffer
  dtc_axil_slave u_slave (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_req     (req),
    .i_rd_data (rd_data)
  );

  dtc_capture_fifo u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (f_clear),
    .i_push    (push),
    .i_data    (i_core_bus.addr),
    .i_pop     (f_pop),
    .o_data    (f_data),
    .o_full    (f_full),
    .o_empty   (f_empty),
    .o_count   (f_count)
  );

  // ==========================================================================
  // Trigger and capture
  assign run   = st_ff.ctrl[dtc_pkg::CTL_EN] && st_ff.ctrl[dtc_pkg::CTL_ARM];
  assign hit_a = cmp_hit(i_core_bus, st_ff.cmpa, st_ff.ctrl[dtc_pkg::CTL_COMP_A_DIR_QUALIFY],
                         st_ff.ctrl[dtc_pkg::CTL_RWA]);
  assign hit_b = cmp_hit(i_core_bus, st_ff.cmpb, st_ff.ctrl[dtc_pkg::CTL_COMP_B_DIR_QUALIFY],
                         st_ff.ctrl[dtc_pkg::CTL_RWB]);
  assign trig  = run && (hit_a || (st_ff.src_or && hit_b));

  always_comb begin
    push = 1'b0;
    done = 1'b0;
    if (run) begin
      if (st_ff.begin_mode) begin
        push = i_core_bus.valid && (st_ff.trig_seen || trig) && !f_full;
        done = st_ff.trig_seen && f_full;
      end else begin
        push = i_core_bus.valid;
        done = trig;
      end
    end
  end

  // ==========================================================================
  // Register access
  assign wr_ctrl = req.wr && req.wstrb[0] && (req.waddr[7:0] == dtc_pkg::OFS_CTRL) &&
                   dtc_pkg::is_mapped(req.waddr);
  assign f_pop   = req.rd && dtc_pkg::is_mapped(req.raddr) &&
                   ({req.raddr[7:2], 2'h0} == dtc_pkg::OFS_BUF);

  always_comb begin
    wctrl = req.wdata[7:0];
    if (st_ff.sec2) begin
      wctrl[dtc_pkg::CTL_EN] = 1'b0;
    end
  end

  assign f_clear = wr_ctrl && wctrl[dtc_pkg::CTL_ARM];

  always_comb begin
    rd_data = 32'h0;
    if (dtc_pkg::is_mapped(req.raddr)) begin
      case ({req.raddr[7:2], 2'h0})
        dtc_pkg::OFS_CTRL:     rd_data = {24'h0, st_ff.ctrl};
        dtc_pkg::OFS_STAT:     rd_data = {24'h0, f_count, f_empty, f_full, st_ff.trig_seen, st_ff.run_active_flag};
        dtc_pkg::OFS_IRQ_STAT: rd_data = {30'h0, st_ff.irq_st};
        dtc_pkg::OFS_IRQ_EN:   rd_data = {30'h0, st_ff.irq_en};
        dtc_pkg::OFS_BUF:      rd_data = {15'h0, !f_empty, f_data};
        dtc_pkg::OFS_TRIG:     rd_data = {30'h0, st_ff.src_or, st_ff.begin_mode};
        dtc_pkg::OFS_CMPA:     rd_data = {16'h0, st_ff.cmpa};
        dtc_pkg::OFS_CMPB:     rd_data = {16'h0, st_ff.cmpb};
        default:               rd_data = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_st      = st_ff;
    irq_set     = '0;
    nxt_st.sec1 = i_secure;
    nxt_st.sec2 = st_ff.sec1;
    nxt_st.brk  = 1'b0;
    if (run && st_ff.begin_mode && trig) begin
      nxt_st.trig_seen = 1'b1;
    end
    if (done) begin
      nxt_st.ctrl[dtc_pkg::CTL_ARM] = 1'b0;
      nxt_st.run_active_flag                   = 1'b0;
      nxt_st.trig_seen              = 1'b0;
      irq_set[dtc_pkg::IRQ_DONE]    = 1'b1;
      if (st_ff.ctrl[dtc_pkg::CTL_BRK]) begin
        nxt_st.brk                = 1'b1;
        nxt_st.brk_tag            = st_ff.ctrl[dtc_pkg::CTL_TAG];
        irq_set[dtc_pkg::IRQ_BRK] = 1'b1;
      end
    end
    if (wr_ctrl) begin
      nxt_st.ctrl = wctrl;
      if (wctrl[dtc_pkg::CTL_ARM]) begin
        nxt_st.run_active_flag      = 1'b1;
        nxt_st.trig_seen = 1'b0;
      end
      if (!wctrl[dtc_pkg::CTL_ARM] || !wctrl[dtc_pkg::CTL_EN]) begin
        nxt_st.ctrl[dtc_pkg::CTL_ARM] = 1'b0;
        nxt_st.run_active_flag                   = 1'b0;
        nxt_st.trig_seen              = 1'b0;
      end
    end
    if (req.wr && dtc_pkg::is_mapped(req.waddr) && req.wstrb[0]) begin
      case ({req.waddr[7:2], 2'h0})
        dtc_pkg::OFS_TRIG: begin
          nxt_st.begin_mode = req.wdata[dtc_pkg::TRG_BEGIN];
          nxt_st.src_or     = req.wdata[dtc_pkg::TRG_SRC];
        end
        dtc_pkg::OFS_IRQ_EN:  nxt_st.irq_en = req.wdata[dtc_pkg::IRQ_W-1:0];
        dtc_pkg::OFS_IRQ_CLR: nxt_st.irq_st = st_ff.irq_st & ~req.wdata[dtc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (req.wr && dtc_pkg::is_mapped(req.waddr)) begin
      case ({req.waddr[7:2], 2'h0})
        dtc_pkg::OFS_CMPA: nxt_st.cmpa = req.wdata[15:0];
        dtc_pkg::OFS_CMPB: nxt_st.cmpb = req.wdata[15:0];
        default: ;
      endcase
    end
    // Events set after the clear so a same-cycle event survives
    nxt_st.irq_st = nxt_st.irq_st | irq_set;
    nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_en);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_ff      <= '0;
      st_ff.ctrl <= dtc_pkg::CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_brk_req = st_ff.brk;
  assign o_brk_tag = st_ff.brk_tag;
  assign o_irq     = st_ff.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  end_break_a: assert property (
    (run && !st_ff.begin_mode && trig && st_ff.ctrl[dtc_pkg::CTL_BRK] && !wr_ctrl)
      |=> o_brk_req && !st_ff.ctrl[dtc_pkg::CTL_ARM])
    else $error("end trace trigger gave no break");
  begin_break_a: assert property (
    (o_brk_req && st_ff.begin_mode) |-> $past(f_full) && $past(st_ff.trig_seen))
    else $error("begin trace break without full buffer");
  break_gate_a: assert property (
    o_brk_req |-> $past(st_ff.ctrl[dtc_pkg::CTL_BRK]) && $past(run))
    else $error("break raised while breaks disabled");
  break_type_a: assert property (
    o_brk_req |-> (o_brk_tag == $past(st_ff.ctrl[dtc_pkg::CTL_TAG])))
    else $error("break type does not follow tag bit");
  secure_en_a: assert property (
    (wr_ctrl && st_ff.sec2) |=> !st_ff.ctrl[dtc_pkg::CTL_EN])
    else $error("enable set while secured");
  arm_set_a: assert property (
    (wr_ctrl && wctrl[dtc_pkg::CTL_ARM] && wctrl[dtc_pkg::CTL_EN])
      |=> st_ff.run_active_flag && st_ff.ctrl[dtc_pkg::CTL_ARM])
    else $error("arm write did not set arm and flag");
  run_stop_a: assert property (
    (wr_ctrl && !(wctrl[dtc_pkg::CTL_ARM] && wctrl[dtc_pkg::CTL_EN])) |=> !run ##1 !o_brk_req)
    else $error("run not stopped by write");
  idle_store_a: assert property (
    !run |-> !push && !done)
    else $error("capture activity while not armed");
  dir_a_a: assert property (
    (hit_a && st_ff.ctrl[dtc_pkg::CTL_COMP_A_DIR_QUALIFY]) |-> (i_core_bus.rd == st_ff.ctrl[dtc_pkg::CTL_RWA]))
    else $error("comparator A matched wrong direction");
  dir_b_a: assert property (
    (hit_b && st_ff.ctrl[dtc_pkg::CTL_COMP_B_DIR_QUALIFY]) |-> (i_core_bus.rd == st_ff.ctrl[dtc_pkg::CTL_RWB]))
    else $error("comparator B matched wrong direction");
  reset_clear_a: assert property (
    $past(i_sys_rst) |-> (st_ff.ctrl == dtc_pkg::CTRL_RST))
    else $error("control register not cleared by reset");
  dir_off_a_a: assert property (
    (i_core_bus.valid && (i_core_bus.addr == st_ff.cmpa) && !st_ff.ctrl[dtc_pkg::CTL_COMP_A_DIR_QUALIFY]) |-> hit_a)
    else $error("comparator A missed with direction ignored");
  dir_off_b_a: assert property (
    (i_core_bus.valid && (i_core_bus.addr == st_ff.cmpb) && !st_ff.ctrl[dtc_pkg::CTL_COMP_B_DIR_QUALIFY]) |-> hit_b)
    else $error("comparator B missed with direction ignored");
  buf_depth_a: assert property (
    f_full |-> (f_count == 4'h8))
    else $error("buffer full at wrong depth");

  end_break_c: cover property (run && !st_ff.begin_mode ##1 o_brk_req);
  begin_break_c: cover property (st_ff.begin_mode && f_full ##1 o_brk_req);
  buf_read_c: cover property (f_pop && !f_empty);
  irq_c: cover property (!o_irq ##1 o_irq);
endmodule // dtc_top
`default_nettype wire

// ===== logic/dtc_pkg.sv
// Package: register map, field positions and carrier types of the debug trigger control
package dtc_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STAT     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFS_BUF      = 8'h14;
  localparam logic [7:0] OFS_TRIG     = 8'h18;
  localparam logic [7:0] OFS_CMPA     = 8'h1c;
  localparam logic [7:0] OFS_CMPB     = 8'h20;
  // ==========================================================================
  // debug_control_reg fields
  localparam int CTL_EN    = 7;
  localparam int CTL_ARM   = 6;
  localparam int CTL_TAG   = 5;
  localparam int CTL_BRK   = 4;
  localparam int CTL_RWA   = 3;
  localparam int CTL_COMP_A_DIR_QUALIFY = 2;
  localparam int CTL_RWB   = 1;
  localparam int CTL_COMP_B_DIR_QUALIFY = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Trigger config fields
  localparam int TRG_BEGIN = 0;
  localparam int TRG_SRC   = 1;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BRK  = 1;
  localparam int IRQ_W    = 2;
  // Capture buffer
  localparam int BUF_DEPTH = 8;
  localparam int BUF_W     = 16;
  localparam int BUF_AW    = 3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  typedef struct packed {
    logic        valid;
    logic        rd;
    logic [15:0] addr;
  } dtc_bus_t;

  typedef struct packed {
    logic        wr;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        rd;
    logic [31:0] raddr;
  } dtc_req_t;

  function automatic logic is_mapped(input logic [31:0] a);
    logic hit;
    hit = 1'b0;
    if (a[31:8] == 24'h000000) begin
      case ({a[7:2], 2'h0})
        OFS_CTRL, OFS_STAT, OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN,
        OFS_BUF, OFS_TRIG, OFS_CMPA, OFS_CMPB: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction
endpackage

// ===== logic/dtc_capture_fifo.sv
// Capture buffer: eight 16-bit entries, oldest entry dropped on push when full
`timescale 1ns/1ps
`default_nettype none
module dtc_capture_fifo (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_clear,
  input  wire logic                       i_push,
  input  wire logic [dtc_pkg::BUF_W-1:0]  i_data,
  input  wire logic                       i_pop,
  output logic      [dtc_pkg::BUF_W-1:0]  o_data,
  output logic                            o_full,
  output logic                            o_empty,
  output logic      [dtc_pkg::BUF_AW:0]   o_count
);
  typedef struct packed {
    logic [dtc_pkg::BUF_DEPTH-1:0][dtc_pkg::BUF_W-1:0] mem;
    logic [dtc_pkg::BUF_AW-1:0]                        wp;
    logic [dtc_pkg::BUF_AW-1:0]                        rp;
    logic [dtc_pkg::BUF_AW:0]                          cnt;
  } dtc_fifo_st_t;

  dtc_fifo_st_t st_ff;
  dtc_fifo_st_t nxt_st;
  logic         full;
  logic         empty;
  logic         pop_ok;

  assign full    = (st_ff.cnt == 4'(dtc_pkg::BUF_DEPTH));
  assign empty   = (st_ff.cnt == 4'h0);
  assign pop_ok  = i_pop && !empty;
  assign o_data  = st_ff.mem[st_ff.rp];
  assign o_full  = full;
  assign o_empty = empty;
  assign o_count = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (i_clear) begin
      nxt_st.wp  = '0;
      nxt_st.rp  = '0;
      nxt_st.cnt = '0;
    end else begin
      if (i_push) begin
        nxt_st.mem[st_ff.wp] = i_data;
        nxt_st.wp = st_ff.wp + 3'h1;
      end
      // A push into a full buffer overwrites the oldest entry
      if (pop_ok || (i_push && full)) begin
        nxt_st.rp = st_ff.rp + 3'h1;
      end
      if (i_push && !pop_ok && !full) begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end else if (pop_ok && !i_push) begin
        nxt_st.cnt = st_ff.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // dtc_capture_fifo
`default_nettype wire

// ===== logic/dtc_axil_slave.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle register requests
`timescale 1ns/1ps
`default_nettype none
module dtc_axil_slave (
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [31:0]       i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic      [1:0]        o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [31:0]       i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic      [31:0]       o_rdata,
  output logic      [1:0]        o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output var dtc_pkg::dtc_req_t  o_req,
  input  wire logic [31:0]       i_rd_data
);
  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        awh;
    logic        wh;
    logic [31:0] aw;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        arrdy;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
  } dtc_axs_st_t;

  dtc_axs_st_t st_ff;
  dtc_axs_st_t nxt_st;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_wr;

  assign aw_take = i_awvalid && st_ff.awrdy;
  assign w_take  = i_wvalid && st_ff.wrdy;
  assign ar_take = i_arvalid && st_ff.arrdy;
  assign do_wr   = st_ff.awh && st_ff.wh && !st_ff.bv;

  always_comb begin
    nxt_st = st_ff;
    if (aw_take) begin
      nxt_st.awh = 1'b1;
      nxt_st.aw  = i_awaddr;
    end
    if (w_take) begin
      nxt_st.wh = 1'b1;
      nxt_st.wd = i_wdata;
      nxt_st.ws = i_wstrb;
    end
    if (st_ff.bv && i_bready) begin
      nxt_st.bv = 1'b0;
    end
    if (do_wr) begin
      nxt_st.awh = 1'b0;
      nxt_st.wh  = 1'b0;
      nxt_st.bv  = 1'b1;
      nxt_st.br  = dtc_pkg::is_mapped(st_ff.aw) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end
    nxt_st.awrdy = !nxt_st.awh;
    nxt_st.wrdy  = !nxt_st.wh;
    if (st_ff.rv && i_rready) begin
      nxt_st.rv = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rv = 1'b1;
      nxt_st.rd = i_rd_data;
      nxt_st.rr = dtc_pkg::is_mapped(i_araddr) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end
    nxt_st.arrdy = !nxt_st.rv && !ar_take;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_awready   = st_ff.awrdy;
  assign o_wready    = st_ff.wrdy;
  assign o_bvalid    = st_ff.bv;
  assign o_bresp     = st_ff.br;
  assign o_arready   = st_ff.arrdy;
  assign o_rvalid    = st_ff.rv;
  assign o_rdata     = st_ff.rd;
  assign o_rresp     = st_ff.rr;
  assign o_req       = '{wr: do_wr, waddr: st_ff.aw, wdata: st_ff.wd, wstrb: st_ff.ws,
                         rd: ar_take, raddr: i_araddr};
endmodule // dtc_axil_slave
`default_nettype wire

// ===== bench/dtc_core_model.sv
// Core model: issues bus cycles and counts break requests
`timescale 1ns/1ps
`default_nettype none
module dtc_core_model (
  input  wire logic         i_sys_clk,
  input  wire logic         i_brk_req,
  input  wire logic         i_brk_tag,
  output var dtc_pkg::dtc_bus_t o_bus
);
  int   brk_cnt  = 0;
  logic tag_seen = 1'b0;

  initial o_bus = '0;

  // One-cycle bus access; idle address is the inverse so stale values never match
  task automatic cycle(input logic [15:0] a, input logic rd);
    o_bus <= '{valid: 1'b1, rd: rd, addr: a};
    @(posedge i_sys_clk);
    o_bus <= '{valid: 1'b0, rd: ~rd, addr: ~a};
  endtask

  always @(posedge i_sys_clk) begin
    if (i_brk_req === 1'b1) begin
      brk_cnt++;
      tag_seen = i_brk_tag;
    end
  end
endmodule // dtc_core_model
`default_nettype wire

// ===== bench/tb_top.sv
// Testbench: register bus, trigger, direction qualify, capture and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              clk     = 1'b0;
  logic              rst     = 1'b1;
  logic [31:0]       awaddr  = '0;
  logic [31:0]       wdata   = '0;
  logic [31:0]       araddr  = '0;
  logic              awvalid = 1'b0;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  logic              secure  = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, brk, tag, irq;
  logic [1:0]        bresp, rresp, wrsp, rrsp;
  logic [31:0]       rdata, v;
  dtc_pkg::dtc_bus_t cbus;
  int                n_errors = 0;
  int                n_tests  = 0;
  localparam logic [15:0] CA = 16'h1234;
  localparam logic [15:0] CB = 16'h5678;

  dtc_top u_dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_core_bus(cbus),
    .i_secure(secure), .o_brk_req(brk), .o_brk_tag(tag), .o_irq(irq));
  dtc_core_model u_core (.i_sys_clk(clk), .i_brk_req(brk), .i_brk_tag(tag), .o_bus(cbus));

  initial forever #2.5 clk = ~clk;

  // ==========================================================================
  // Bus and compare helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && k < 60);
    wrsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
    if (k >= 60) chk("write answer", 1, 0);
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && k < 60);
    v = rdata;
    rrsp = rresp;
    rready <= 1'b0;
    @(posedge clk);
    if (k >= 60) chk("read answer", 1, 0);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, v);
  endtask

  task automatic fire(input logic [15:0] a, input logic d, input int nb, input logic tg);
    int b0;
    b0 = u_core.brk_cnt;
    u_core.cycle(a, d);
    repeat (4) @(posedge clk);
    chk("break count", nb, u_core.brk_cnt - b0);
    if (nb > 0) chk("break tag", {31'h0, tg}, {31'h0, u_core.tag_seen});
  endtask

  task automatic run(input logic [7:0] c, input logic [1:0] t, input logic [15:0] a, input logic d,
                     input int nb, input logic tg);
    wr(dtc_pkg::OFS_TRIG, {30'h0, t});
    wr(dtc_pkg::OFS_CTRL, {24'h0, c});
    fire(a, d, nb, tg);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_reset();
    rchk("ctrl reset", dtc_pkg::OFS_CTRL, 32'h0);
    chk("mapped read resp", {30'h0, dtc_pkg::RESP_OKAY}, {30'h0, rrsp});
    rd(8'h40);
    chk("unmapped resp", {30'h0, dtc_pkg::RESP_SLVERR}, {30'h0, rrsp});
    chk("unmapped data", 32'h0, v);
    wr(8'h40, 32'hff);
    chk("unmapped write resp", {30'h0, dtc_pkg::RESP_SLVERR}, {30'h0, wrsp});
    wr(dtc_pkg::OFS_CMPA, {16'h0, CA});
    chk("mapped write resp", {30'h0, dtc_pkg::RESP_OKAY}, {30'h0, wrsp});
    wr(dtc_pkg::OFS_CMPB, {16'h0, CB});
  endtask

  task automatic s_secure();
    secure <= 1'b1;
    repeat (4) @(posedge clk);
    wr(dtc_pkg::OFS_CTRL, 32'h80);
    rchk("enable while secured", dtc_pkg::OFS_CTRL, 32'h0);
    secure <= 1'b0;
    repeat (4) @(posedge clk);
    wr(dtc_pkg::OFS_CTRL, 32'h80);
    rchk("enable when open", dtc_pkg::OFS_CTRL, 32'h80);
  endtask

  task automatic s_break();
    wr(dtc_pkg::OFS_TRIG, 32'h0);
    wr(dtc_pkg::OFS_CTRL, 32'hd0);
    rchk("armed flag", dtc_pkg::OFS_STAT, 32'h9);
    fire(CB, 1'b0, 0, 1'b0);
    fire(CA, 1'b0, 1, 1'b0);
    rchk("arm cleared", dtc_pkg::OFS_CTRL, 32'h90);
    run(8'hf0, 2'h0, CA, 1'b1, 1, 1'b1);
    run(8'hc0, 2'h0, CA, 1'b0, 0, 1'b0);
    rchk("run ended", dtc_pkg::OFS_CTRL, 32'h80);
  endtask

  task automatic s_dir();
    logic [1:0] q;
    logic [7:0] c;
    for (int i = 0; i < 16; i++) begin
      q = {i[1], i[2]};
      c = i[3] ? {6'h34, q} : {4'hd, q, 2'h0};
      run(c, {i[3] | i[0], 1'b0}, i[3] ? CB : CA, i[0], (!i[2] || i[1] == i[0]) ? 1 : 0, 1'b0);
    end
  endtask

  task automatic s_begin();
    wr(dtc_pkg::OFS_TRIG, 32'h1);
    wr(dtc_pkg::OFS_CTRL, 32'hd0);
    fire(CA, 1'b0, 0, 1'b0);
    for (int k = 1; k < 7; k++) fire(16'h0100 + 16'(k), 1'b1, 0, 1'b0);
    rchk("seven stored", dtc_pkg::OFS_STAT, 32'h73);
    rchk("ctrl mid run", dtc_pkg::OFS_CTRL, 32'hd0);
    fire(16'h0200, 1'b0, 1, 1'b0);
    rd(dtc_pkg::OFS_STAT);
    chk("full count", 32'h11, {27'h0, v[7:4], v[2]});
    rchk("oldest entry", dtc_pkg::OFS_BUF, {15'h0, 1'b1, CA});
  endtask

  task automatic s_stop();
    wr(dtc_pkg::OFS_TRIG, 32'h0);
    wr(dtc_pkg::OFS_CTRL, 32'hd0);
    wr(dtc_pkg::OFS_CTRL, 32'h90);
    fire(CA, 1'b0, 0, 1'b0);
    wr(dtc_pkg::OFS_CTRL, 32'hd0);
    wr(dtc_pkg::OFS_CTRL, 32'h50);
    fire(CA, 1'b0, 0, 1'b0);
  endtask

  task automatic s_irq();
    wr(dtc_pkg::OFS_IRQ_CLR, 32'h3);
    wr(dtc_pkg::OFS_IRQ_EN, 32'h1);
    run(8'hd0, 2'h0, CA, 1'b0, 1, 1'b0);
    chk("irq raised", 1, {31'h0, irq});
    wr(dtc_pkg::OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, {31'h0, irq});
    wr(dtc_pkg::OFS_IRQ_EN, 32'h1);
    wr(dtc_pkg::OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, {31'h0, irq});
    rchk("irq status", dtc_pkg::OFS_IRQ_STAT, 32'h2);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    s_reset();
    s_secure();
    s_break();
    s_dir();
    s_begin();
    s_stop();
    s_irq();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
